// ===== hdl/idc_decode_top.sv
// Instruction decode and cycle control: word pairing, inserted cycles, skips
`default_nettype none
module idc_decode_top (
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  input  wire idc_pkg::idc_fetch_type fetchWord,
  input  wire logic                condTaken,
  output logic                     fetchReady,
  output idc_pkg::idc_issue_type   issue
);
  logic [1:0]               rstPipe_reg;
  logic [1:0]               rstPipe_next;
  logic                     rstN;
  idc_pkg::idc_decoded_type dec;
  idc_pkg::idc_decoded_type held_reg;
  idc_pkg::idc_decoded_type held_next;
  idc_pkg::idc_state_type   state_reg;
  idc_pkg::idc_state_type   state_next;
  idc_pkg::idc_issue_type   issue_reg;
  idc_pkg::idc_issue_type   issue_next;
  logic [1:0]               nopLeft_reg;
  logic [1:0]               nopLeft_next;
  logic                     ready_reg;
  logic                     ready_next;
  logic                     accept;
  logic [1:0]               extraNow;
  logic                     nextIsTwo;

  // Reset release synchroniser
  always_comb
  begin
    rstPipe_next = {rstPipe_reg[0], 1'b1};
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rstPipe_reg <= idc_pkg::RST_PIPE;
    else
      rstPipe_reg <= rstPipe_next;
  end

  assign rstN = rstPipe_reg[1];

  // Field split of the word now on the fetch port
  idc_field_decode uDecode (
    .word (fetchWord.word),
    .dec  (dec)
  );

  // A word is taken only while ready is shown
  assign accept = fetchWord.valid && ready_reg;
  assign nextIsTwo = idc_pkg::idc_is_two_word(fetchWord.word[idc_pkg::OPC_LSB +: idc_pkg::OPC_W]);

  // Extra cycles owed by the word being taken
  always_comb
  begin
    extraNow = dec.extra;
    if (dec.condOp && condTaken)
      extraNow = idc_pkg::EXTRA_TAKEN;
  end

  // Sequencer: next state, inserted cycles and issued instruction
  always_comb
  begin
    state_next = state_reg;
    nopLeft_next = nopLeft_reg;
    ready_next = ready_reg;
    held_next = held_reg;
    issue_next = '0;
    case (state_reg)
      idc_pkg::ST_RUN:
      begin
        if (accept)
        begin
          if (dec.twoWord)
          begin
            // Operands incomplete: wait for the second word
            held_next = dec;
            state_next = idc_pkg::ST_WORD2;
          end
          else
          begin
            issue_next.valid = 1'b1;
            issue_next.dec = dec;
            issue_next.cycles = idc_pkg::BASE_CYC + extraNow;
            if (dec.skipOp && condTaken)
            begin
              // Cost depends on the length of the word skipped over
              issue_next.cycles = idc_pkg::SKIP_CYC;
              state_next = idc_pkg::ST_SKIP;
            end
            else if (extraNow != 2'h0)
            begin
              nopLeft_next = extraNow;
              ready_next = 1'b0;
              state_next = idc_pkg::ST_NOPS;
            end
          end
        end
      end
      idc_pkg::ST_NOPS:
      begin
        // Fetch is stalled while no-operations fill the slot
        issue_next.valid = 1'b1;
        issue_next.inserted = 1'b1;
        issue_next.dec.group = idc_pkg::GRP_CONTROL;
        issue_next.dec.form = idc_pkg::FORM_CTRL;
        issue_next.dec.opcode = idc_pkg::OPC_NOP;
        issue_next.cycles = idc_pkg::BASE_CYC;
        nopLeft_next = nopLeft_reg - 2'h1;
        if (nopLeft_reg == 2'h1)
        begin
          ready_next = 1'b1;
          state_next = idc_pkg::ST_RUN;
        end
      end
      idc_pkg::ST_WORD2:
      begin
        if (accept)
        begin
          issue_next.valid = 1'b1;
          issue_next.dec = held_reg;
          issue_next.ext = fetchWord.word[0 +: idc_pkg::PAY_W];
          issue_next.word2Bad = (fetchWord.word[idc_pkg::OPC_LSB +: idc_pkg::OPC_W]
                                 != idc_pkg::OPC_NOP);
          issue_next.cycles = idc_pkg::TWO_WORD_CYC;
          state_next = idc_pkg::ST_RUN;
        end
      end
      idc_pkg::ST_SKIP, idc_pkg::ST_SKIP2:
      begin
        if (accept)
        begin
          // Skipped word is swallowed as a no-operation
          issue_next.valid = 1'b1;
          issue_next.inserted = 1'b1;
          issue_next.dec.group = idc_pkg::GRP_CONTROL;
          issue_next.dec.form = idc_pkg::FORM_CTRL;
          issue_next.dec.opcode = idc_pkg::OPC_NOP;
          issue_next.cycles = idc_pkg::BASE_CYC;
          if (state_reg == idc_pkg::ST_SKIP && nextIsTwo)
            state_next = idc_pkg::ST_SKIP2;
          else
            state_next = idc_pkg::ST_RUN;
        end
      end
      default:
      begin
        ready_next = 1'b1;
        state_next = idc_pkg::ST_RUN;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_reg <= idc_pkg::ST_RUN;
      nopLeft_reg <= 2'h0;
      ready_reg <= idc_pkg::READY_RST;
      held_reg <= '0;
      issue_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      nopLeft_reg <= nopLeft_next;
      ready_reg <= ready_next;
      held_reg <= held_next;
      issue_reg <= issue_next;
    end
  end

  assign fetchReady = ready_reg;
  assign issue = issue_reg;

  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rstN);

  opcode_split_a: assert property (
    accept && state_reg == idc_pkg::ST_RUN && !dec.twoWord
    |=> issue_reg.valid
        && issue_reg.dec.opcode == $past(fetchWord.word[23:16]))
    else $error("opcode not taken from top byte");

  two_word_a: assert property (
    accept && state_reg == idc_pkg::ST_RUN && dec.twoWord
    |=> !issue_reg.valid && state_reg == idc_pkg::ST_WORD2)
    else $error("two-word start issued early");

  word2_top_a: assert property (
    accept && state_reg == idc_pkg::ST_WORD2
    |=> issue_reg.valid
        && issue_reg.word2Bad == ($past(fetchWord.word[23:16]) != 8'h00)
        && issue_reg.ext == $past(fetchWord.word[15:0]))
    else $error("second word check wrong");

  orphan_nop_a: assert property (
    accept && state_reg == idc_pkg::ST_RUN && fetchWord.word[23:16] == 8'h00
    |=> issue_reg.dec.group == idc_pkg::GRP_CONTROL
        && issue_reg.cycles == 2'h1 && ready_reg)
    else $error("orphan second word not a no-operation");

  one_cycle_a: assert property (
    accept && state_reg == idc_pkg::ST_RUN && !dec.twoWord
    && dec.extra == 2'h0 && !condTaken
    |=> ready_reg && state_reg == idc_pkg::ST_RUN)
    else $error("plain instruction stalled");

  taken_nop_a: assert property (
    accept && state_reg == idc_pkg::ST_RUN && dec.condOp && condTaken
    |=> !ready_reg ##1 (issue_reg.inserted && ready_reg))
    else $error("taken condition lacks one inserted cycle");

  return_three_a: assert property (
    accept && state_reg == idc_pkg::ST_RUN
    && (dec.opcode == idc_pkg::OPC_RETURN || dec.opcode == idc_pkg::OPC_INT_EXIT)
    |=> !ready_reg [*2] ##1 ready_reg)
    else $error("return not three cycles");

  skip_long_a: assert property (
    accept && state_reg == idc_pkg::ST_SKIP && nextIsTwo
    |=> state_reg == idc_pkg::ST_SKIP2 && issue_reg.inserted)
    else $error("skip over two-word not three cycles");

  dw_move_a: assert property (
    accept && state_reg == idc_pkg::ST_RUN && dec.opcode == idc_pkg::OPC_DW_MOV
    |=> issue_reg.cycles == 2'h2 ##1 issue_reg.inserted)
    else $error("double-word move not two cycles");

  file_dest_a: assert property (
    issue_reg.valid && issue_reg.dec.form == idc_pkg::FORM_FILE
    |-> issue_reg.dec.dstReg == idc_pkg::ACCUM_REG)
    else $error("file destination register wrong");

  lit_dest_a: assert property (
    issue_reg.valid && issue_reg.dec.form == idc_pkg::FORM_LIT_ARITH
    && !issue_reg.dec.sepDest
    |-> issue_reg.dec.dstReg == issue_reg.dec.baseReg)
    else $error("literal destination not base register");
endmodule : idc_decode_top
`default_nettype wire

// ===== hdl/idc_pkg.sv
// Package: word layout, opcodes, cycle counts and carrier types of the decoder
// Behaviour
// - Single-word instructions are 24-bit words with an 8-bit opcode field.
// - Exactly three instruction types take two program words; others take one.
// - Two-word instructions carry 48 bits; second word's top byte must be zero.
// - A second word executed alone behaves as a no-operation.
// - Plain single-word instructions finish in one cycle.
// - True condition or program counter change costs one inserted no-operation cycle.
// - Branches, indirect jumps, table accesses and returns take two or three cycles.
// - Taken skip costs two cycles over one word, three over two words.
// - Double-word moves and all two-word instructions take two cycles.
// - Working-register operations decode base, source and destination operands.
// - File-register operations decode a file address and file-or-accumulator destination.
// - Bit operations name a target and take bit position from literal or base.
// - Literal arithmetic uses base and literal; own destination field only if separate.
// - Literal moves load a value into a working or file register.
// - Every instruction falls in one of four groups.
// - Working-register fields select one of sixteen registers.
`default_nettype none
package idc_pkg;
  localparam int OPC_W        = 8;
  localparam int OPC_LSB      = 16;
  localparam int REG_W        = 4;
  localparam int MODE_W       = 2;
  localparam int FILE_W       = 13;
  localparam int PAY_W        = 16;
  localparam int BASE_LSB     = 12;
  localparam int DST_REG_LSB  = 8;
  localparam int DST_MODE_LSB = 6;
  localparam int SRC_MODE_LSB = 4;
  localparam int SRC_REG_LSB  = 0;
  localparam int ACC_BIT      = 13;
  localparam int BITF_W       = 12;
  localparam int LIT5_LSB     = 6;
  localparam int LIT5_W       = 5;
  localparam int LITW_LSB     = 4;
  localparam int LITW_W       = 12;
  localparam int LITF_LSB     = 8;
  localparam int LITF_W       = 8;
  localparam int FADDR8_W     = 8;
  // Opcode upper nibble picks the operand form
  localparam logic [3:0] NIB_DEFAULT_ACCUMULATOR_REG = 4'h1;
  localparam logic [3:0] NIB_FILE = 4'h2;
  localparam logic [3:0] NIB_BIT  = 4'h3;
  localparam logic [3:0] NIB_LITA = 4'h4;
  localparam logic [3:0] NIB_LITM = 4'h5;
  // Control opcodes; all-zero byte is the no-operation
  localparam logic [7:0] OPC_NOP        = 8'h00;
  localparam logic [7:0] OPC_REL_BRANCH = 8'h01;
  localparam logic [7:0] OPC_ABS_JUMP   = 8'h02;
  localparam logic [7:0] OPC_CALL       = 8'h03;
  localparam logic [7:0] OPC_LONG_MOV   = 8'h04;
  localparam logic [7:0] OPC_IND_JUMP   = 8'h05;
  localparam logic [7:0] OPC_RETURN     = 8'h06;
  localparam logic [7:0] OPC_INT_EXIT   = 8'h07;
  localparam logic [7:0] OPC_TBL_RD     = 8'h08;
  localparam logic [7:0] OPC_TBL_WR     = 8'h09;
  localparam logic [7:0] OPC_COND_BR    = 8'h0A;
  localparam logic [7:0] OPC_SKIP       = 8'h0B;
  localparam logic [7:0] OPC_DW_MOV     = 8'h0C;
  localparam logic [3:0] ACCUM_REG      = 4'h0;
  localparam logic [1:0] MODE_DIRECT    = 2'h0;
  // Cycle figures
  localparam logic [1:0] BASE_CYC     = 2'h1;
  localparam logic [1:0] EXTRA_TAKEN  = 2'h1;
  localparam logic [1:0] EXTRA_BRANCH = 2'h1;
  localparam logic [1:0] EXTRA_TABLE  = 2'h1;
  localparam logic [1:0] EXTRA_RETURN = 2'h2;
  localparam logic [1:0] EXTRA_DW_MOV = 2'h1;
  localparam logic [1:0] TWO_WORD_CYC = 2'h2;
  localparam logic [1:0] SKIP_CYC     = 2'h2;
  localparam logic [1:0] RST_PIPE     = 2'h0;
  localparam logic       READY_RST    = 1'b1;

  typedef enum logic [1:0] {GRP_WORDBYTE, GRP_BIT, GRP_LITERAL, GRP_CONTROL} idc_group_type;
  typedef enum logic [2:0] {FORM_W3, FORM_FILE, FORM_BIT, FORM_LIT_ARITH,
                            FORM_LIT_MOVE, FORM_CTRL} idc_form_type;
  typedef enum logic [2:0] {ST_RUN, ST_NOPS, ST_WORD2, ST_SKIP, ST_SKIP2} idc_state_type;

  typedef struct packed {
    logic        valid;
    logic [23:0] word;
  } idc_fetch_type;

  typedef struct packed {
    idc_group_type     group;
    idc_form_type      form;
    logic [7:0]        opcode;
    logic              byteMode;
    logic [REG_W-1:0]  baseReg;
    logic [REG_W-1:0]  srcReg;
    logic [MODE_W-1:0] srcMode;
    logic [REG_W-1:0]  dstReg;
    logic [MODE_W-1:0] dstMode;
    logic [FILE_W-1:0] fileAddr;
    logic              destAccum;
    logic              fileTarget;
    logic [REG_W-1:0]  bitPos;
    logic              bitFromReg;
    logic [PAY_W-1:0]  literal;
    logic              sepDest;
    logic              twoWord;
    logic              condOp;
    logic              skipOp;
    logic [1:0]        extra;
  } idc_decoded_type;

  typedef struct packed {
    logic             valid;
    logic             inserted;
    logic             word2Bad;
    logic [1:0]       cycles;
    logic [PAY_W-1:0] ext;
    idc_decoded_type  dec;
  } idc_issue_type;

  // Opcodes whose operands spill into a second program word
  function automatic logic idc_is_two_word(input logic [7:0] opc);
    return (opc == OPC_ABS_JUMP) || (opc == OPC_CALL) || (opc == OPC_LONG_MOV);
  endfunction : idc_is_two_word
endpackage : idc_pkg
`default_nettype wire

// ===== hdl/idc_field_decode.sv
// Combinational split of one program word into group, form and operand fields
`default_nettype none
module idc_field_decode (
  input  wire logic [23:0]             word,
  output idc_pkg::idc_decoded_type     dec
);
  // Field extraction per operand form
  always_comb
  begin
    dec = '0;
    dec.opcode = word[idc_pkg::OPC_LSB +: idc_pkg::OPC_W];
    dec.group = idc_pkg::GRP_CONTROL;
    dec.form = idc_pkg::FORM_CTRL;
    case (dec.opcode[7:4])
      idc_pkg::NIB_DEFAULT_ACCUMULATOR_REG:
      begin
        dec.group = idc_pkg::GRP_WORDBYTE;
        dec.form = idc_pkg::FORM_W3;
        dec.byteMode = dec.opcode[0];
        dec.baseReg = word[idc_pkg::BASE_LSB +: idc_pkg::REG_W];
        dec.dstReg = word[idc_pkg::DST_REG_LSB +: idc_pkg::REG_W];
        dec.dstMode = word[idc_pkg::DST_MODE_LSB +: idc_pkg::MODE_W];
        dec.srcMode = word[idc_pkg::SRC_MODE_LSB +: idc_pkg::MODE_W];
        dec.srcReg = word[idc_pkg::SRC_REG_LSB +: idc_pkg::REG_W];
      end
      idc_pkg::NIB_FILE:
      begin
        dec.group = idc_pkg::GRP_WORDBYTE;
        dec.form = idc_pkg::FORM_FILE;
        dec.byteMode = dec.opcode[0];
        dec.fileAddr = word[0 +: idc_pkg::FILE_W];
        dec.destAccum = word[idc_pkg::ACC_BIT];
        dec.dstReg = idc_pkg::ACCUM_REG;
      end
      idc_pkg::NIB_BIT:
      begin
        dec.group = idc_pkg::GRP_BIT;
        dec.form = idc_pkg::FORM_BIT;
        dec.fileTarget = dec.opcode[0];
        dec.bitFromReg = dec.opcode[1];
        if (dec.fileTarget)
          dec.fileAddr = idc_pkg::FILE_W'(word[0 +: idc_pkg::BITF_W]);
        else
        begin
          dec.srcMode = word[idc_pkg::SRC_MODE_LSB +: idc_pkg::MODE_W];
          dec.srcReg = word[idc_pkg::SRC_REG_LSB +: idc_pkg::REG_W];
        end
        // Same field holds either the position or the register holding it
        if (dec.bitFromReg)
          dec.baseReg = word[idc_pkg::BASE_LSB +: idc_pkg::REG_W];
        else
          dec.bitPos = word[idc_pkg::BASE_LSB +: idc_pkg::REG_W];
      end
      idc_pkg::NIB_LITA:
      begin
        dec.group = idc_pkg::GRP_LITERAL;
        dec.form = idc_pkg::FORM_LIT_ARITH;
        dec.baseReg = word[idc_pkg::BASE_LSB +: idc_pkg::REG_W];
        dec.literal = idc_pkg::PAY_W'(word[idc_pkg::LIT5_LSB +: idc_pkg::LIT5_W]);
        dec.sepDest = dec.opcode[0];
        if (dec.sepDest)
        begin
          dec.dstReg = word[idc_pkg::SRC_REG_LSB +: idc_pkg::REG_W];
          dec.dstMode = word[idc_pkg::SRC_MODE_LSB +: idc_pkg::MODE_W];
        end
        else
        begin
          dec.dstReg = dec.baseReg;
          dec.dstMode = idc_pkg::MODE_DIRECT;
        end
      end
      idc_pkg::NIB_LITM:
      begin
        dec.group = idc_pkg::GRP_LITERAL;
        dec.form = idc_pkg::FORM_LIT_MOVE;
        dec.fileTarget = dec.opcode[0];
        if (dec.fileTarget)
        begin
          dec.literal = idc_pkg::PAY_W'(word[idc_pkg::LITF_LSB +: idc_pkg::LITF_W]);
          dec.fileAddr = idc_pkg::FILE_W'(word[0 +: idc_pkg::FADDR8_W]);
        end
        else
        begin
          dec.literal = idc_pkg::PAY_W'(word[idc_pkg::LITW_LSB +: idc_pkg::LITW_W]);
          dec.baseReg = word[0 +: idc_pkg::REG_W];
        end
      end
      default:
      begin
        // Unknown control codes fall through as a one-cycle no-operation
        dec.twoWord = idc_pkg::idc_is_two_word(dec.opcode);
        case (dec.opcode)
          idc_pkg::OPC_REL_BRANCH: dec.extra = idc_pkg::EXTRA_BRANCH;
          idc_pkg::OPC_IND_JUMP:   dec.extra = idc_pkg::EXTRA_BRANCH;
          idc_pkg::OPC_RETURN:     dec.extra = idc_pkg::EXTRA_RETURN;
          idc_pkg::OPC_INT_EXIT:   dec.extra = idc_pkg::EXTRA_RETURN;
          idc_pkg::OPC_TBL_RD:     dec.extra = idc_pkg::EXTRA_TABLE;
          idc_pkg::OPC_TBL_WR:     dec.extra = idc_pkg::EXTRA_TABLE;
          idc_pkg::OPC_DW_MOV:     dec.extra = idc_pkg::EXTRA_DW_MOV;
          idc_pkg::OPC_COND_BR:    dec.condOp = 1'b1;
          idc_pkg::OPC_SKIP:       dec.skipOp = 1'b1;
          default:                 dec.extra = 2'h0;
        endcase
      end
    endcase
  end
endmodule : idc_field_decode
`default_nettype wire

// ===== bench/idc_fetch_model.sv
// Program memory fetch path model that feeds queued words to the decoder
`default_nettype none
module idc_fetch_model (
  input  wire logic                ref_clk,
  input  wire logic                slow,
  input  wire logic                fetchReady,
  output var idc_pkg::idc_fetch_type fetchWord,
  output logic                     condTaken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [24:0] wordQ[$];
  logic [24:0] cur;
  logic        busy;

  // Queue one word together with its condition result
  task automatic push(input logic [23:0] w, input logic c);
    wordQ.push_back({c, w});
  endtask : push

  // Quiet bus at time zero
  initial
  begin
    fetchWord = '0;
    condTaken = 1'b0;
    busy = 1'b0;
    cur = '0;
  end

  // A word is held unchanged until the edge that sees ready high
  always @(posedge ref_clk)
  begin
    if (busy && fetchReady === 1'b1)
      busy = 1'b0;
    if (!busy && wordQ.size() != 0 && (slow !== 1'b1 || $urandom_range(2) == 0))
    begin
      cur = wordQ.pop_front();
      busy = 1'b1;
      fetchWord.word <= cur[23:0];
      condTaken <= cur[24];
    end
    else if (!busy)
    begin
      fetchWord.word <= ~fetchWord.word; // Idle bus toggles, so a stale word never looks valid
      condTaken <= ~condTaken;
    end
    fetchWord.valid <= busy;
  end
endmodule : idc_fetch_model
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for instruction decode and cycle control
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic                   ins;
    logic [1:0]             cyc;
    logic                   bad;
    logic [7:0]             opc;
    idc_pkg::idc_group_type grp;
    logic [15:0]            key;
  } idc_exp_type;
  localparam logic [7:0] CTL_OPS [11] = '{8'h00, 8'h01, 8'h05, 8'h06, 8'h07, 8'h08,
                                         8'h09, 8'h0A, 8'h0A, 8'h0C, 8'hFF};
  logic                   ref_clk;
  logic                   nrst;
  logic                   slow;
  logic                   condTaken;
  logic                   fetchReady;
  idc_pkg::idc_fetch_type fetchWord;
  idc_pkg::idc_issue_type issue;
  idc_exp_type            expQ[$];
  int                     mismatches;
  int                     checks;
  int                     swallow;
  logic                   secondDue;
  logic [7:0]             firstOp;

  idc_decode_top idc_decode_top_inst (.ref_clk(ref_clk), .nrst(nrst), .fetchWord(fetchWord),
    .condTaken(condTaken), .fetchReady(fetchReady), .issue(issue));
  idc_fetch_model idc_fetch_model_inst (.ref_clk(ref_clk), .slow(slow),
    .fetchReady(fetchReady), .fetchWord(fetchWord), .condTaken(condTaken));

  // Operand fingerprint expected from a raw word, per operand form
  function automatic logic [15:0] word_key(input logic [23:0] w);
    case (w[23:20])
      4'h1: return w[15:0];
      4'h2: return {2'h0, w[13:0]};
      4'h3: return {10'h000, w[15:12], w[17:16]};
      4'h4: return {6'h00, w[15:12], w[10:6], w[16]};
      4'h5: return w[16] ? {8'h00, w[15:8]} : {4'h0, w[15:4]};
      default: return 16'h0000;
    endcase
  endfunction : word_key

  // Same fingerprint gathered from the decoded fields
  function automatic logic [15:0] seen_key(input idc_pkg::idc_issue_type s);
    case (s.dec.opcode[7:4])
      4'h1: return {s.dec.baseReg, s.dec.dstReg, s.dec.dstMode, s.dec.srcMode, s.dec.srcReg};
      4'h2: return {2'h0, s.dec.destAccum, s.dec.fileAddr};
      // Position field lands in baseReg when it names a register, else in bitPos
      4'h3: return {10'h000, s.dec.bitFromReg ? s.dec.baseReg : s.dec.bitPos,
                    s.dec.bitFromReg, s.dec.fileTarget};
      4'h4: return {6'h00, s.dec.baseReg, s.dec.literal[4:0], s.dec.sepDest};
      4'h5: return s.dec.literal;
      default: return s.dec.twoWord ? s.ext : 16'h0000;
    endcase
  endfunction : seen_key

  // Group follows the upper opcode nibble
  function automatic idc_pkg::idc_group_type grp_of(input logic [7:0] op);
    case (op[7:4])
      4'h1, 4'h2: return idc_pkg::GRP_WORDBYTE;
      4'h3: return idc_pkg::GRP_BIT;
      4'h4, 4'h5: return idc_pkg::GRP_LITERAL;
      default: return idc_pkg::GRP_CONTROL;
    endcase
  endfunction : grp_of

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", name, e, s);
    end
  endtask : chk

  task automatic note(input logic i, input logic [1:0] c, input logic b,
                      input logic [7:0] o, input logic [15:0] k);
    expQ.push_back('{i, c, b, o, grp_of(o), k});
  endtask : note

  // Hand a word to the fetch model and note the issue cycles it must cause
  task automatic send(input logic [23:0] w, input logic c);
    logic [7:0] op;
    logic [1:0] cyc;
    op = w[23:16];
    idc_fetch_model_inst.push(w, c);
    if (swallow > 0)
    begin
      swallow = swallow - 1 + int'(op inside {8'h02, 8'h03, 8'h04});
      note(1'b1, 2'h0, 1'b0, op, 16'h0000);
    end
    else if (secondDue)
    begin
      secondDue = 1'b0;
      note(1'b0, 2'h2, op != 8'h00, firstOp, w[15:0]);
    end
    else if (op inside {8'h02, 8'h03, 8'h04})
    begin
      secondDue = 1'b1;
      firstOp = op;
    end
    else
    begin
      cyc = (op inside {8'h06, 8'h07}) ? 2'h3 :
            (op inside {8'h01, 8'h05, 8'h08, 8'h09, 8'h0C} ||
             (c && op inside {8'h0A, 8'h0B})) ? 2'h2 : 2'h1;
      note(1'b0, cyc, 1'b0, op, word_key(w));
      if (op == 8'h0B)
        swallow = int'(c);
      else
        repeat (int'(cyc) - 1) note(1'b1, 2'h0, 1'b0, op, 16'h0000);
    end
  endtask : send

  task automatic drain(input string name);
    int n;
    n = 0;
    while (expQ.size() != 0 && n < 2000)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk("pending issues", 32'h0, 32'(expQ.size()));
    $display("test %s done", name);
  endtask : drain

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // 125 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Each issued cycle retires the oldest note; mid-cycle so values are settled
  always @(negedge ref_clk)
  begin
    idc_exp_type e;
    if (nrst === 1'b1 && issue.valid !== 1'b0)
    begin
      if (expQ.size() == 0)
        chk("spare issue", 32'h0, 32'h1);
      else
      begin
        e = expQ.pop_front();
        chk("inserted", e.ins, issue.inserted);
        if (!e.ins)
        begin
          chk("cycles", e.cyc, issue.cycles);
          chk("opcode", e.opc, issue.dec.opcode);
          chk("group", e.grp, issue.dec.group);
          chk("operands", e.key, seen_key(issue));
          chk("second word flag", e.bad, issue.word2Bad);
        end
      end
    end
  end

  // Hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    $display("watchdog expired");
    print_verdict();
  end

  // Fast back-to-back pass first, then a pass with fetch gaps
  initial
  begin
    nrst = 1'b0;
    slow = 1'b0;
    mismatches = 0;
    checks = 0;
    swallow = 0;
    secondDue = 1'b0;
    firstOp = 8'h00;
    void'($urandom(31318));
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int pass = 0; pass < 2; pass++)
    begin
      slow <= pass[0];
      repeat (40) send({4'($urandom_range(5, 1)), 4'($urandom), 16'($urandom)}, 1'b0);
      drain("operand forms");
      for (int i = 0; i < 11; i++)
        send({CTL_OPS[i], 16'($urandom)}, i == 8);
      drain("control cycles");
      for (int i = 2; i < 5; i++)
      begin
        send({8'(i), 16'($urandom)}, 1'b0);
        send({8'h00, 16'($urandom)}, 1'b0);
      end
      send({8'h03, 16'($urandom)}, 1'b0);
      send({8'h5A, 16'($urandom)}, 1'b0);
      send({8'h00, 16'($urandom)}, 1'b0);
      drain("two-word");
      send({8'h0B, 16'($urandom)}, 1'b0);
      send({8'h1C, 16'($urandom)}, 1'b0);
      send({8'h0B, 16'($urandom)}, 1'b1);
      send({8'h21, 16'($urandom)}, 1'b0);
      send({8'h0B, 16'($urandom)}, 1'b1);
      send({8'h02, 16'($urandom)}, 1'b0);
      send({8'h00, 16'($urandom)}, 1'b0);
      send({8'h06, 16'($urandom)}, 1'b0);
      drain("skips");
    end
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
